// ---- hw/two_wire_slave.sv ----
// Two-wire register slave: decodes start/stop, address, 16-bit pointer, byte writes and reads.
// Assumes bus lines oversampled by clk (at least 8 clocks per bus clock phase) and a
// user memory that presents rd_data for reg_ptr combinationally.
`timescale 1ns/1ns
module two_wire_slave (
  input  wire logic               clk,
  input  wire logic               reset,
  two_wire_if.device              bus,
  input  wire logic               address_select_input,
  input  wire logic [7:0]         rd_data,
  output logic      [15:0]        reg_ptr,
  output logic      [15:0]        wr_addr,
  output logic      [7:0]         wr_data,
  output logic                    wr_strobe,
  output logic                    rd_strobe,
  output logic                    busy,
  output logic                    addressed
);
  typedef enum logic [5:0] {
    S_IDLE   = 6'b000001,
    S_RX     = 6'b000010,
    S_ACK    = 6'b000100,
    S_TX     = 6'b001000,
    S_MACK   = 6'b010000,
    S_IGNORE = 6'b100000
  } slave_state_t;

  slave_state_t            state;
  slave_state_t            next_state;
  two_wire_pkg::byte_kind_t kind;
  two_wire_pkg::byte_kind_t next_kind;
  logic [1:0]              scl_sync;
  logic [1:0]              sda_sync;
  logic [1:0]              sel_sync;
  logic                    scl_d;
  logic                    sda_d;
  logic [7:0]              shift;
  logic [7:0]              next_shift;
  logic [3:0]              bit_cnt;
  logic [3:0]              next_cnt;
  logic                    rw;
  logic                    next_rw;
  logic [15:0]             next_ptr;
  logic                    drive_low;
  logic                    next_drive;
  logic                    master_ack;
  logic                    next_master_ack;
  logic                    next_wr;
  logic                    next_rd;
  logic                    next_busy;
  logic                    next_addressed;

  wire scl_now = scl_sync[1];
  wire sda_now = sda_sync[1];
  wire scl_rise = scl_now && !scl_d;
  wire scl_fall = !scl_now && scl_d;
  wire start_seen = scl_now && scl_d && sda_d && !sda_now;
  wire stop_seen = scl_now && scl_d && !sda_d && sda_now;
  wire bus_idle = scl_now && sda_now;
  wire byte_done = scl_fall && (bit_cnt == two_wire_pkg::ACK_BIT);
  wire [7:0] own_wr = sel_sync[1] ? two_wire_pkg::ADDR_SEL_HIGH_WR : two_wire_pkg::ADDR_SEL_LOW_WR;
  wire addr_match = (shift[7:1] == own_wr[7:1]);
  wire last_tx_bit = (bit_cnt == two_wire_pkg::LAST_DATA_BIT);
  wire [15:0] ptr_inc = reg_ptr + two_wire_pkg::PTR_STEP;
  wire [7:0] shift_up = {shift[6:0], 1'b0};

  // Only the open-drain data enable ever drives; the clock is input only
  assign bus.dev_sda_out = 1'b0;
  assign bus.dev_sda_oe = drive_low;

  always_comb begin
    next_state = state;
    next_kind = kind;
    next_shift = shift;
    next_cnt = bit_cnt;
    next_rw = rw;
    next_ptr = reg_ptr;
    next_drive = drive_low;
    next_master_ack = master_ack;
    next_wr = 1'b0;
    next_rd = 1'b0;
    next_addressed = addressed;
    next_busy = busy;
    if (stop_seen) begin
      next_state = S_IDLE;
      next_drive = 1'b0;
      next_addressed = 1'b0;
      next_busy = 1'b0;
    end else if (start_seen) begin
      next_state = S_RX;
      next_kind = two_wire_pkg::KIND_SLAVE;
      next_cnt = two_wire_pkg::BIT_CNT_ZERO;
      next_drive = 1'b0;
      next_addressed = 1'b0;
      next_busy = 1'b1;
    end else begin
      if (state == S_IDLE && bus_idle) begin
        next_busy = 1'b0;
      end
      unique case (state)
        S_IDLE, S_IGNORE: begin
          next_drive = 1'b0;
        end
        S_RX: begin
          if (scl_rise) begin
            next_shift = {shift[6:0], sda_now};
            next_cnt = bit_cnt + two_wire_pkg::BIT_CNT_ONE;
          end else if (byte_done) begin
            if (kind == two_wire_pkg::KIND_SLAVE) begin
              if (addr_match) begin
                next_rw = shift[0];
                next_drive = 1'b1;
                next_state = S_ACK;
                next_addressed = 1'b1;
              end else begin
                next_state = S_IGNORE;
              end
            end else begin
              next_drive = 1'b1;
              next_state = S_ACK;
              unique case (kind)
                two_wire_pkg::KIND_REG_HI: next_ptr = {shift, reg_ptr[7:0]};
                two_wire_pkg::KIND_REG_LO: next_ptr = {reg_ptr[15:8], shift};
                default: begin
                  next_wr = 1'b1;
                  next_ptr = ptr_inc;
                end
              endcase
            end
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            next_cnt = two_wire_pkg::BIT_CNT_ZERO;
            if (kind == two_wire_pkg::KIND_SLAVE && rw) begin
              next_shift = rd_data;
              next_drive = !rd_data[7];
              next_rd = 1'b1;
              next_state = S_TX;
            end else begin
              next_drive = 1'b0;
              next_state = S_RX;
              if (kind != two_wire_pkg::KIND_DATA) begin
                next_kind = two_wire_pkg::byte_kind_t'(kind + 2'h1);
              end
            end
          end
        end
        S_TX: begin
          if (scl_fall) begin
            if (last_tx_bit) begin
              next_drive = 1'b0;
              next_ptr = ptr_inc;
              next_state = S_MACK;
            end else begin
              next_shift = shift_up;
              next_drive = !shift[6];
              next_cnt = bit_cnt + two_wire_pkg::BIT_CNT_ONE;
            end
          end
        end
        S_MACK: begin
          if (scl_rise) begin
            next_master_ack = !sda_now;
          end else if (scl_fall) begin
            if (master_ack) begin
              next_shift = rd_data;
              next_drive = !rd_data[7];
              next_rd = 1'b1;
              next_cnt = two_wire_pkg::BIT_CNT_ZERO;
              next_state = S_TX;
            end else begin
              next_state = S_IGNORE;
            end
          end
        end
        default: begin
          next_state = S_IDLE;
          next_drive = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    scl_sync <= {scl_sync[0], bus.serial_clock};
    sda_sync <= {sda_sync[0], bus.serial_data_line};
    sel_sync <= {sel_sync[0], address_select_input};
    scl_d <= scl_sync[1];
    sda_d <= sda_sync[1];
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= S_IDLE;
      kind <= two_wire_pkg::KIND_SLAVE;
      shift <= 8'h00;
      bit_cnt <= two_wire_pkg::BIT_CNT_ZERO;
      rw <= 1'b0;
      reg_ptr <= two_wire_pkg::PTR_RESET;
      drive_low <= 1'b0;
      master_ack <= 1'b0;
      wr_strobe <= 1'b0;
      rd_strobe <= 1'b0;
      busy <= 1'b0;
      addressed <= 1'b0;
    end else begin
      state <= next_state;
      kind <= next_kind;
      shift <= next_shift;
      bit_cnt <= next_cnt;
      rw <= next_rw;
      reg_ptr <= next_ptr;
      drive_low <= next_drive;
      master_ack <= next_master_ack;
      wr_strobe <= next_wr;
      rd_strobe <= next_rd;
      busy <= next_busy;
      addressed <= next_addressed;
    end
  end

  // Write address and data hold until the next written byte
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_addr <= two_wire_pkg::PTR_RESET;
      wr_data <= 8'h00;
    end else if (next_wr) begin
      wr_addr <= reg_ptr;
      wr_data <= shift;
    end
  end
endmodule

// ---- hw/two_wire_pkg.sv ----
// Shared constants and types for the two-wire register port, slave and master ends.
// Assumes one 50 MHz system clock on both ends.
package two_wire_pkg;
  // Write address bytes of the two selectable pairs; the read byte sets bit 0
  localparam logic [7:0] ADDR_SEL_LOW_WR  = 8'h90;
  localparam logic [7:0] ADDR_SEL_HIGH_WR = 8'hBA;
  localparam int         BYTE_BITS        = 8;
  localparam int         REG_ADDR_BITS    = 16;
  localparam int         DEV_ADDR_BITS    = 7;
  localparam logic [3:0] LAST_DATA_BIT    = 4'h7;
  localparam logic [3:0] ACK_BIT          = 4'h8;
  localparam logic [3:0] BIT_CNT_ZERO     = 4'h0;
  localparam logic [3:0] BIT_CNT_ONE      = 4'h1;
  localparam logic [15:0] PTR_RESET       = 16'h0000;
  localparam logic [15:0] PTR_STEP        = 16'h0001;

  // Master clock generation
  localparam int SYS_CLK_MHZ    = 50;
  localparam int SCL_PERIOD_NS  = 640;
  localparam int QUARTER_CYCLES = (SCL_PERIOD_NS * SYS_CLK_MHZ + 3999) / 4000;
  // Bus clock must stay at or below the pixel clock divided by this
  localparam int PIXEL_CLK_RATIO = 22;

  typedef enum logic [1:0] {
    KIND_SLAVE  = 2'h0,
    KIND_REG_HI = 2'h1,
    KIND_REG_LO = 2'h2,
    KIND_DATA   = 2'h3
  } byte_kind_t;

  typedef enum logic [1:0] {
    CMD_WRITE        = 2'h0,
    CMD_READ_RANDOM  = 2'h1,
    CMD_READ_CURRENT = 2'h2
  } cmd_t;

  typedef enum logic [1:0] {
    OP_START = 2'h0,
    OP_BYTE  = 2'h1,
    OP_STOP  = 2'h2
  } step_op_t;

  // Master sequence steps
  localparam logic [3:0] STEP_START      = 4'h0;
  localparam logic [3:0] STEP_WR_ADDR    = 4'h1;
  localparam logic [3:0] STEP_REG_HI     = 4'h2;
  localparam logic [3:0] STEP_REG_LO     = 4'h3;
  localparam logic [3:0] STEP_RESTART    = 4'h4;
  localparam logic [3:0] STEP_RD_ADDR    = 4'h5;
  localparam logic [3:0] STEP_READ_ACK   = 4'h6;
  localparam logic [3:0] STEP_READ_NACK  = 4'h7;
  localparam logic [3:0] STEP_READ_STOP  = 4'h8;
  localparam logic [3:0] STEP_WRITE_STOP = 4'h6;
endpackage

// ---- hw/two_wire_if.sv ----
// Two-wire bus between the register slave and the host master.
// The data line is open drain: low while any enabled driver drives low.
`timescale 1ns/1ns
interface two_wire_if;
  logic serial_clock;
  logic host_sda_out;
  logic host_sda_oe;
  logic dev_sda_out;
  logic dev_sda_oe;
  logic serial_data_line;

  assign serial_data_line = !(host_sda_oe && !host_sda_out) && !(dev_sda_oe && !dev_sda_out);

  modport device (
    input  serial_clock,
    input  serial_data_line,
    output dev_sda_out,
    output dev_sda_oe
  );
  modport host (
    output serial_clock,
    output host_sda_out,
    output host_sda_oe,
    input  serial_data_line
  );
endinterface

// ---- hw/two_wire_master.sv ----
// Host end: runs one 16-bit register write or read per command on the two-wire bus.
// Assumes the slave does not stretch the clock; the bus clock is made here by a divider.
`timescale 1ns/1ns
module two_wire_master #(
  parameter int QUARTER = two_wire_pkg::QUARTER_CYCLES
) (
  input  wire logic               clk,
  input  wire logic               reset,
  two_wire_if.host                bus,
  input  wire logic               cmd_valid,
  input  wire two_wire_pkg::cmd_t cmd_kind,
  input  wire logic [6:0]         cmd_dev,
  input  wire logic [15:0]        cmd_reg,
  input  wire logic [15:0]        cmd_data,
  output logic                    cmd_ready,
  output logic                    rsp_valid,
  output logic      [15:0]        rsp_data,
  output logic                    rsp_nack
);
  typedef enum logic [3:0] {
    H_IDLE  = 4'b0001,
    H_START = 4'b0010,
    H_BYTE  = 4'b0100,
    H_STOP  = 4'b1000
  } host_state_t;

  host_state_t        state;
  two_wire_pkg::cmd_t kind;
  logic [6:0]         dev;
  logic [15:0]        regad;
  logic [15:0]        data;
  logic [15:0]        div;
  logic               tick;
  logic [1:0]         quarter;
  logic [3:0]         bitn;
  logic [3:0]         step;
  logic               scl;
  logic               sda_low;
  logic [1:0]         sda_sync;

  function automatic two_wire_pkg::step_op_t step_op(two_wire_pkg::cmd_t k, logic [3:0] s);
    logic rd;
    rd = (k != two_wire_pkg::CMD_WRITE);
    if (s == two_wire_pkg::STEP_START || (rd && s == two_wire_pkg::STEP_RESTART)) begin
      return two_wire_pkg::OP_START;
    end
    if (rd ? (s == two_wire_pkg::STEP_READ_STOP) : (s == two_wire_pkg::STEP_WRITE_STOP)) begin
      return two_wire_pkg::OP_STOP;
    end
    return two_wire_pkg::OP_BYTE;
  endfunction

  wire is_read = (kind != two_wire_pkg::CMD_WRITE);
  wire is_rx = is_read && (step == two_wire_pkg::STEP_READ_ACK || step == two_wire_pkg::STEP_READ_NACK);
  wire [7:0] tx_byte = (step == two_wire_pkg::STEP_WR_ADDR) ? {dev, 1'b0} :
                       (step == two_wire_pkg::STEP_REG_HI)  ? regad[15:8] :
                       (step == two_wire_pkg::STEP_REG_LO)  ? regad[7:0] :
                       (step == two_wire_pkg::STEP_RD_ADDR) ? (is_read ? {dev, 1'b1} : data[7:0]) :
                       data[15:8];
  wire in_data = (bitn < two_wire_pkg::ACK_BIT);
  wire tx_bit = tx_byte[3'(two_wire_pkg::LAST_DATA_BIT - bitn)];
  // Master drives its ack after every read byte but the last, which gets a nack
  wire level = in_data ? (is_rx ? 1'b1 : tx_bit) : (is_rx ? (step == two_wire_pkg::STEP_READ_NACK) : 1'b1);
  wire sda_now = sda_sync[1];
  wire two_wire_pkg::step_op_t op_next = step_op(kind, step + 4'h1);

  assign bus.serial_clock = scl;
  assign bus.host_sda_out = 1'b0;
  assign bus.host_sda_oe = sda_low;

  // Divider sets the bus clock; keep it at or below the slave's pixel clock / 22
  always_ff @(posedge clk) begin
    if (reset || state == H_IDLE || div == 16'(QUARTER - 1)) begin
      div <= 16'h0000;
    end else begin
      div <= div + 16'h0001;
    end
    tick <= !reset && state != H_IDLE && div == 16'(QUARTER - 1);
    sda_sync <= {sda_sync[0], bus.serial_data_line};
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= H_IDLE;
      kind <= two_wire_pkg::CMD_WRITE;
      dev <= 7'h00;
      regad <= 16'h0000;
      data <= 16'h0000;
      quarter <= 2'h0;
      bitn <= 4'h0;
      step <= 4'h0;
      scl <= 1'b1;
      sda_low <= 1'b0;
      cmd_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_data <= 16'h0000;
      rsp_nack <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      unique case (state)
        H_IDLE: begin
          if (cmd_valid && cmd_ready) begin
            kind <= cmd_kind;
            dev <= cmd_dev;
            regad <= cmd_reg;
            data <= cmd_data;
            step <= (cmd_kind == two_wire_pkg::CMD_READ_CURRENT) ? two_wire_pkg::STEP_RESTART
                                                                 : two_wire_pkg::STEP_START;
            quarter <= 2'h0;
            rsp_nack <= 1'b0;
            cmd_ready <= 1'b0;
            state <= H_START;
          end
        end
        H_START: begin
          if (tick) begin
            quarter <= quarter + 2'h1;
            unique case (quarter)
              2'h0: begin
                scl <= 1'b0;
                sda_low <= 1'b0;
              end
              2'h1: scl <= 1'b1;
              2'h2: sda_low <= 1'b1;
              default: begin
                scl <= 1'b0;
                step <= step + 4'h1;
                bitn <= 4'h0;
                state <= H_BYTE;
              end
            endcase
          end
        end
        H_BYTE: begin
          if (tick) begin
            quarter <= quarter + 2'h1;
            unique case (quarter)
              2'h0: sda_low <= !level;
              2'h1: scl <= 1'b1;
              2'h2: begin
                if (in_data && is_rx) begin
                  rsp_data <= {rsp_data[14:0], sda_now};
                end
                if (!in_data && !is_rx && sda_now) begin
                  rsp_nack <= 1'b1;
                end
              end
              default: begin
                scl <= 1'b0;
                if (in_data) begin
                  bitn <= bitn + 4'h1;
                end else begin
                  bitn <= 4'h0;
                  step <= step + 4'h1;
                  if (rsp_nack || op_next == two_wire_pkg::OP_STOP) begin
                    state <= H_STOP;
                  end else if (op_next == two_wire_pkg::OP_START) begin
                    state <= H_START;
                  end
                end
              end
            endcase
          end
        end
        H_STOP: begin
          if (tick) begin
            quarter <= quarter + 2'h1;
            unique case (quarter)
              2'h0: begin
                scl <= 1'b0;
                sda_low <= 1'b1;
              end
              2'h1: scl <= 1'b1;
              2'h2: sda_low <= 1'b0;
              default: begin
                rsp_valid <= 1'b1;
                cmd_ready <= 1'b1;
                state <= H_IDLE;
              end
            endcase
          end
        end
        default: state <= H_IDLE;
      endcase
    end
  end
endmodule

// ---- dv/two_wire_chk.sv ----
// Concurrent checks on the two-wire bus joining the slave and master ends.
// Assumes the bus lines are sampled by the 50 MHz system clock.
`timescale 1ns/1ns
module two_wire_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic serial_clock,
  input wire logic host_sda_out,
  input wire logic host_sda_oe,
  input wire logic dev_sda_out,
  input wire logic dev_sda_oe,
  input wire logic serial_data_line
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  a_dev_pull_low: assert property (dev_sda_oe |-> !serial_data_line)
    else $error("slave drive left data line high");
  a_ack_held_high: assert property ($rose(dev_sda_oe) |-> !serial_clock ##1
    (dev_sda_oe throughout ##[0:40] serial_clock))
    else $error("slave released data before clock high");
  a_oe_fall_low: assert property ($fell(dev_sda_oe) |-> !serial_clock)
    else $error("slave released data while clock high");
  a_oe_steady_high: assert property (serial_clock && $past(serial_clock) |-> $stable(dev_sda_oe))
    else $error("slave data changed while clock high");
  a_start_quiet: assert property ($fell(serial_data_line) && serial_clock && $past(serial_clock)
    |-> ##1 !dev_sda_oe [*8])
    else $error("slave drove data right after start");
  a_stop_quiet: assert property ($rose(serial_data_line) && serial_clock && $past(serial_clock)
    |-> !dev_sda_oe [*8])
    else $error("slave drove data right after stop");
  a_single_driver: assert property (serial_clock |-> !(host_sda_oe && dev_sda_oe))
    else $error("both ends drive data while clock high");
  a_clk_high_len: assert property ($rose(serial_clock) |-> serial_clock [*6])
    else $error("bus clock high phase too short");

  c_start: cover property ($fell(serial_data_line) && serial_clock && $past(serial_clock));
  c_stop: cover property ($rose(serial_data_line) && serial_clock && $past(serial_clock));
  c_dev_ack: cover property ($rose(dev_sda_oe));
endmodule

// ---- dv/tb.sv ----
// Self-checking bench: master and slave ends joined on one two-wire bus.
// Assumes the master's default bus divider; the register memory is modelled here.
`timescale 1ns/1ns
module tb;
  logic               clk;
  logic               reset;
  logic               address_select_input;
  logic [7:0]         rd_data;
  logic [15:0]        reg_ptr;
  logic [15:0]        wr_addr;
  logic [7:0]         wr_data;
  logic               wr_strobe;
  logic               rd_strobe;
  logic               busy;
  logic               addressed;
  logic               cmd_valid;
  two_wire_pkg::cmd_t cmd_kind;
  logic [6:0]         cmd_dev;
  logic [15:0]        cmd_reg;
  logic [15:0]        cmd_data;
  logic               cmd_ready;
  logic               rsp_valid;
  logic [15:0]        rsp_data;
  logic               rsp_nack;
  logic [7:0]         mem [0:65535];
  logic [7:0]         ref_mem [0:65535];
  logic [15:0]        exp_ptr;
  logic [15:0]        exp_data;
  logic [15:0]        r;
  logic [15:0]        d;
  logic [7:0]         mon_byte = 8'h00;
  logic [7:0]         mon_shift = 8'h00;
  logic [3:0]         mon_bits = 4'h8;
  logic               scl_q = 1'b1;
  logic               sda_q = 1'b1;
  logic [7:0]         dev_byte;
  logic               sel;
  logic               wrong;
  logic [1:0]         kk;
  integer             seed;
  integer             rnd;
  int                 err_total;
  int                 check_count;
  int                 wr_count = 0;
  int                 rd_count = 0;
  int                 addr_cycles = 0;
  int                 busy_cycles = 0;
  int                 wr_base;
  int                 rd_base;
  int                 addr_base;
  int                 busy_base;

  two_wire_if bus ();

  two_wire_slave i_two_wire_slave (
    .clk                  (clk),
    .reset                (reset),
    .bus                  (bus),
    .address_select_input (address_select_input),
    .rd_data              (rd_data),
    .reg_ptr              (reg_ptr),
    .wr_addr              (wr_addr),
    .wr_data              (wr_data),
    .wr_strobe            (wr_strobe),
    .rd_strobe            (rd_strobe),
    .busy                 (busy),
    .addressed            (addressed)
  );

  two_wire_master i_two_wire_master (
    .clk       (clk),
    .reset     (reset),
    .bus       (bus),
    .cmd_valid (cmd_valid),
    .cmd_kind  (cmd_kind),
    .cmd_dev   (cmd_dev),
    .cmd_reg   (cmd_reg),
    .cmd_data  (cmd_data),
    .cmd_ready (cmd_ready),
    .rsp_valid (rsp_valid),
    .rsp_data  (rsp_data),
    .rsp_nack  (rsp_nack)
  );

  two_wire_chk i_two_wire_chk (
    .clk              (clk),
    .reset            (reset),
    .serial_clock     (bus.serial_clock),
    .host_sda_out     (bus.host_sda_out),
    .host_sda_oe      (bus.host_sda_oe),
    .dev_sda_out      (bus.dev_sda_out),
    .dev_sda_oe       (bus.dev_sda_oe),
    .serial_data_line (bus.serial_data_line)
  );

  assign rd_data = mem[reg_ptr];

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // User memory, strobe counts, and a monitor keeping the first byte after each start
  always @(posedge clk) begin
    if (reset) begin
      for (int a = 0; a < 65536; a++) begin
        mem[a] <= init_val(16'(a));
      end
    end else if (wr_strobe) begin
      mem[wr_addr] <= wr_data;
      wr_count <= wr_count + 1;
    end
    if (rd_strobe) rd_count <= rd_count + 1;
    if (addressed) addr_cycles <= addr_cycles + 1;
    if (busy) busy_cycles <= busy_cycles + 1;
    if (scl_q && bus.serial_clock && sda_q && !bus.serial_data_line) mon_bits <= 4'h0;
    else if (!scl_q && bus.serial_clock && mon_bits < 4'h8) begin
      mon_shift <= {mon_shift[6:0], bus.serial_data_line};
      mon_bits  <= mon_bits + 4'h1;
      if (mon_bits == 4'h7) mon_byte <= {mon_shift[6:0], bus.serial_data_line};
    end
    scl_q <= bus.serial_clock;
    sda_q <= bus.serial_data_line;
  end

  function automatic logic [7:0] init_val(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction

  function automatic logic [7:0] exp_addr(input logic s, input logic rd);
    return (s ? 8'hBA : 8'h90) | {7'h00, rd};
  endfunction

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("Checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // One command, held for one clock, then a bounded wait for the response
  task automatic run(input logic [1:0] k, input logic [6:0] dev);
    int n;
    wr_base = wr_count;
    rd_base = rd_count;
    addr_base = addr_cycles;
    busy_base = busy_cycles;
    cmd_valid = 1'b1;
    cmd_kind = two_wire_pkg::cmd_t'(k);
    cmd_dev = dev;
    cmd_reg = r;
    cmd_data = d;
    @(negedge clk);
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 6000) begin
      @(negedge clk);
      n++;
    end
    if (rsp_valid !== 1'b1) begin
      err_total++;
      $display("Error rsp_valid expected 1 seen 0");
      print_verdict();
    end
  endtask

  initial begin
    seed = 99371;
    err_total = 0;
    check_count = 0;
    reset = 1'b1;
    cmd_valid = 1'b0;
    cmd_kind = two_wire_pkg::CMD_WRITE;
    cmd_dev = 7'h00;
    cmd_reg = 16'h0000;
    cmd_data = 16'h0000;
    address_select_input = 1'b0;
    exp_ptr = 16'h0000;
    for (int a = 0; a < 65536; a++) begin
      ref_mem[a] = init_val(16'(a));
    end
    repeat (3) @(negedge clk);
    reset = 1'b0;
    chk("reg_ptr", 16'h0000, reg_ptr);
    // Address 0xFFFF first so the pointer wraps
    for (int i = 0; i < 24; i++) begin
      rnd = $random(seed);
      sel = rnd[0];
      r = (i < 4) ? 16'hFFFF : rnd[31:16];
      rnd = $random(seed);
      d = rnd[15:0];
      kk = 2'(i % 4);
      wrong = (kk == 2'h3);
      if (wrong) kk = 2'($unsigned(rnd[31:16]) % 3);
      address_select_input = sel;
      repeat (4) @(negedge clk);
      exp_data = (kk == 2'h1) ? {ref_mem[r], ref_mem[r + 16'h0001]} : {ref_mem[exp_ptr], ref_mem[exp_ptr + 16'h0001]};
      dev_byte = exp_addr(sel ^ wrong, 1'b0);
      run(kk, dev_byte[7:1]);
      if (!wrong && kk == 2'h0) begin
        ref_mem[r] = d[15:8];
        ref_mem[r + 16'h0001] = d[7:0];
      end
      if (!wrong) exp_ptr = (kk == 2'h2 ? exp_ptr : r) + 16'h0002;
      chk("rsp_nack", {15'h0000, wrong}, {15'h0000, rsp_nack});
      if (!wrong && kk != 2'h0) chk("rsp_data", exp_data, rsp_data);
      chk("reg_ptr", exp_ptr, reg_ptr);
      chk("wr_count", (!wrong && kk == 2'h0) ? 16'h0002 : 16'h0000, 16'(wr_count - wr_base));
      chk("rd_count", (!wrong && kk != 2'h0) ? 16'h0002 : 16'h0000, 16'(rd_count - rd_base));
      chk("addressed_seen", {15'h0000, !wrong}, {15'h0000, addr_cycles != addr_base});
      chk("busy_seen", 16'h0001, {15'h0000, busy_cycles != busy_base});
      chk("addr_byte", {8'h00, exp_addr(sel ^ wrong, kk == 2'h2 || (kk == 2'h1 && !wrong))}, {8'h00, mon_byte});
      chk("busy_addressed", 16'h0000, {14'h0000, busy, addressed});
      chk("idle_lines", 16'h0003, {14'h0000, bus.serial_clock, bus.serial_data_line});
    end
    print_verdict();
  end
endmodule
